// ===== iat_params.svh
// constants of the interrupt acceptance timing block: offsets, fields, resets, state counts
// assumes one state of the response sequence equals one ref_clk cycle
`ifndef IAT_PARAMS_SVH
`define IAT_PARAMS_SVH

`define IAT_ADDR_CTRL      8'h00
`define IAT_ADDR_FLAGS     8'h04
`define IAT_ADDR_ENABLE    8'h08
`define IAT_ADDR_STATUS    8'h0C

`define IAT_CTRL_NMIEDGE   0
`define IAT_CTRL_MEM_LO    1
`define IAT_CTRL_MEM_HI    2
`define IAT_CTRL_3ST       3
`define IAT_CTRL_WAIT_LO   4
`define IAT_CTRL_WAIT_HI   5

`define IAT_CTRL_RST       6'h00
`define IAT_EN_RST         6'h00
`define IAT_IMASK_RST      1'h1

`define IAT_PRIO_EXT       5'h02
`define IAT_PRIO_INT       5'h01
`define IAT_CUR_ONCHIP     6'h17
`define IAT_CUR_8B2        6'h1B
`define IAT_CUR_8B3        6'h1F
`define IAT_CUR_16B2       6'h17
`define IAT_CUR_16B3       6'h19
`define IAT_ACC_ONCHIP     5'h04
`define IAT_ACC_8B2        5'h08
`define IAT_ACC_8B3        5'h0C
`define IAT_ACC_16B2       5'h04
`define IAT_ACC_16B3       5'h06
`define IAT_ACC_CNT_8B     5'h04
`define IAT_ACC_CNT_16B    5'h02
`define IAT_INTERNAL       5'h04

`define IAT_BRK_OP         16'h5770
`define IAT_RTB_OP         16'h56F0

`define IAT_RESP_OKAY      2'h0
`define IAT_RESP_SLVERR    2'h2

`endif

// ===== iat_pkg.sv
// types shared by the interrupt acceptance timing block
// assumes the constants header is included by the modules that use the package
package iat_pkg;

    // gray codes along idle -> prio -> wait -> stack -> vector -> prefetch -> internal
    typedef enum logic [2:0] {
        IAT_IDLE  = 3'h0,
        IAT_PRIO  = 3'h1,
        IAT_WAIT  = 3'h3,
        IAT_STACK = 3'h2,
        IAT_VECT  = 3'h6,
        IAT_PREF  = 3'h7,
        IAT_INTL  = 3'h5
    } iat_phase_t;

    typedef enum logic [2:0] {
        IAT_CL_NORMAL = 3'h0,
        IAT_CL_CTRL   = 3'h1,
        IAT_CL_BLKB   = 3'h2,
        IAT_CL_BLKW   = 3'h3
    } iat_class_t;

    typedef enum logic [1:0] {
        IAT_MEM_ONCHIP = 2'h0,
        IAT_MEM_BUS8   = 2'h1,
        IAT_MEM_BUS16  = 2'h2
    } iat_mem_t;

endpackage : iat_pkg

// ===== iat_nmi_edge.sv
// nmi pin synchroniser and selectable edge detector
// assumes nmi_pin is asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module iat_nmi_edge (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic nmi_pin,
    input  wire logic edge_rise,
    output logic      nmi_pulse
);
    import iat_pkg::*;

    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_q      <= 1'b0;
            s2_q      <= 1'b0;
            s3_q      <= 1'b0;
            nmi_pulse <= 1'b0;
        end
        else
        begin
            s1_q      <= nmi_pin;
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            nmi_pulse <= edge_rise ? (s2_q & ~s3_q) : (~s2_q & s3_q);
        end
    end
endmodule : iat_nmi_edge
`default_nettype wire

// ===== iat_ext_flags.sv
// external request flags: set on a rising pin edge, cleared by writing 0 after reading 1
// assumes irq pins are asynchronous; rd_stb and wr_stb are one-cycle pulses from the bus
`timescale 1ns/1ps
`default_nettype none
module iat_ext_flags (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [5:0] irq_pin,
    input  wire logic       rd_stb,
    input  wire logic       wr_stb,
    input  wire logic [5:0] wr_val,
    output logic      [5:0] ext_request_flag
);
    import iat_pkg::*;

    logic [5:0] s1_q;
    logic [5:0] s2_q;
    logic [5:0] s3_q;
    logic [5:0] armed_q;
    logic [5:0] hazard_q;
    logic       rd_open_q;
    logic [5:0] rise;
    logic [5:0] clr;

    assign rise = s2_q & ~s3_q;
    // a flag that rose after the read but before the write-back is lost too
    assign clr  = {6{wr_stb}} & ~wr_val & (armed_q | hazard_q);

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_q <= 6'h00;
            s2_q <= 6'h00;
            s3_q <= 6'h00;
        end
        else
        begin
            s1_q <= irq_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            armed_q   <= 6'h00;
            hazard_q  <= 6'h00;
            rd_open_q <= 1'b0;
        end
        else if (wr_stb)
        begin
            armed_q   <= 6'h00;
            hazard_q  <= 6'h00;
            rd_open_q <= 1'b0;
        end
        else if (rd_stb)
        begin
            armed_q   <= armed_q | ext_request_flag;
            rd_open_q <= 1'b1;
        end
        else if (rd_open_q)
        begin
            hazard_q <= hazard_q | rise;
        end
    end

    // set wins over clear in the same cycle
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            ext_request_flag <= 6'h00;
        else
            ext_request_flag <= (ext_request_flag & ~clr) | rise;
    end
endmodule : iat_ext_flags
`default_nettype wire

// ===== iat_core.sv
// interrupt acceptance and response timing with an axi4-lite register slave
// assumes the cpu core reports instruction ends, opcode and class on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "iat_params.svh"
module iat_core (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [7:0]          awaddr,
    input  wire logic                wvalid,
    output logic                     wready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    output logic                     bvalid,
    input  wire logic                bready,
    output logic      [1:0]          bresp,
    input  wire logic                arvalid,
    output logic                     arready,
    input  wire logic [7:0]          araddr,
    output logic                     rvalid,
    input  wire logic                rready,
    output logic      [31:0]         rdata,
    output logic      [1:0]          rresp,
    input  wire logic                nmi_pin,
    input  wire logic [5:0]          irq_pin,
    input  wire logic [1:0]          int_req,
    input  wire logic                insn_done,
    input  wire logic [15:0]         insn_opcode,
    input  wire iat_pkg::iat_class_t insn_class,
    input  wire logic                xfer_boundary,
    input  wire logic                ccr_wr,
    input  wire logic                ccr_i_val,
    output iat_pkg::iat_phase_t      exc_phase,
    output logic                     svc_start,
    output logic      [3:0]          vector_id,
    output logic                     ret_next,
    output logic                     ccr_imask,
    output logic                     break_mode,
    output logic                     wdt_halt
);
    import iat_pkg::*;

    function automatic logic [4:0] acc_len(input iat_mem_t m, input logic st3,
                                          input logic [1:0] ws);
        logic [4:0] l;
        l = `IAT_ACC_ONCHIP;
        unique case (m)
            IAT_MEM_BUS8:  l = st3 ? 5'(`IAT_ACC_8B3 + 5'(ws) * `IAT_ACC_CNT_8B) : `IAT_ACC_8B2;
            IAT_MEM_BUS16: l = st3 ? 5'(`IAT_ACC_16B3 + 5'(ws) * `IAT_ACC_CNT_16B)
                                   : `IAT_ACC_16B2;
            default:       l = `IAT_ACC_ONCHIP;
        endcase
        return l;
    endfunction : acc_len

    function automatic logic [5:0] cur_max(input iat_mem_t m, input logic st3,
                                          input logic [1:0] ws);
        logic [5:0] c;
        c = `IAT_CUR_ONCHIP;
        unique case (m)
            IAT_MEM_BUS8:  c = st3 ? 6'(`IAT_CUR_8B3 + 6'(ws) * 6'h08) : `IAT_CUR_8B2;
            IAT_MEM_BUS16: c = st3 ? 6'(`IAT_CUR_16B3 + 6'(ws) * 6'h04) : `IAT_CUR_16B2;
            default:       c = `IAT_CUR_ONCHIP;
        endcase
        return c;
    endfunction : cur_max

    function automatic logic [3:0] first_set(input logic [8:0] v);
        logic [3:0] id;
        id = 4'hF;
        for (int i = 8; i >= 0; i--)
        begin
            if (v[i])
                id = 4'(i);
        end
        return id;
    endfunction : first_set

    logic [5:0]  ctrl_q;
    logic [5:0]  en_q;
    logic [5:0]  view_q;
    logic [5:0]  ext_request_flag;
    logic        nmi_pulse;
    logic        nmi_pend_q;
    iat_phase_t  st_q;
    logic [4:0]  cnt_q;
    logic [5:0]  wcnt_q;
    logic        wait_over_q;
    logic        prio_ext_q;
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  awaddr_q;
    logic [5:0]  wbyte_q;
    logic        wlane_q;
    logic        wr_fire;
    logic        flags_rd;
    logic        flags_wr;
    logic [8:0]  reqs;
    logic [8:0]  elig;
    logic [3:0]  pick;
    logic        brk_now;
    logic        rtb_now;
    logic        blk_w_on;
    logic        boundary;
    iat_mem_t    mem;
    logic        st3;
    logic [1:0]  ws;

    assign mem      = iat_mem_t'(ctrl_q[`IAT_CTRL_MEM_HI:`IAT_CTRL_MEM_LO]);
    assign st3      = ctrl_q[`IAT_CTRL_3ST];
    assign ws       = st3 ? ctrl_q[`IAT_CTRL_WAIT_HI:`IAT_CTRL_WAIT_LO] : 2'h0;
    assign wr_fire  = aw_have_q & w_have_q & ~bvalid;
    assign flags_wr = wr_fire & wlane_q & (awaddr_q == `IAT_ADDR_FLAGS);
    assign flags_rd = arvalid & arready & (araddr == `IAT_ADDR_FLAGS);
    assign brk_now  = insn_done & (insn_opcode == `IAT_BRK_OP);
    assign rtb_now  = insn_done & (insn_opcode == `IAT_RTB_OP);
    assign blk_w_on = (insn_class == IAT_CL_BLKW) & ~insn_done;
    assign boundary = insn_done | (xfer_boundary & blk_w_on);

    // word move lets only nmi through; byte move and break let nothing through
    assign reqs = {int_req, view_q, nmi_pend_q};
    always_comb
    begin
        elig = reqs;
        if (ccr_imask || blk_w_on)
            elig = reqs & 9'h001;
        if (break_mode || brk_now || ((insn_class == IAT_CL_BLKB) && !insn_done))
            elig = 9'h000;
    end
    assign pick = first_set(elig);

    iat_nmi_edge u_nmi (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .nmi_pin   (nmi_pin),
        .edge_rise (ctrl_q[`IAT_CTRL_NMIEDGE]),
        .nmi_pulse (nmi_pulse)
    );

    iat_ext_flags u_flags (
        .ref_clk          (ref_clk),
        .resetn           (resetn),
        .irq_pin          (irq_pin),
        .rd_stb           (flags_rd),
        .wr_stb           (flags_wr),
        .wr_val           (wbyte_q),
        .ext_request_flag (ext_request_flag)
    );

    // requests only drop at an instruction end, so a clear takes effect after it
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            view_q <= 6'h00;
        else if (insn_done)
            view_q <= ext_request_flag & en_q;
        else
            view_q <= view_q | (ext_request_flag & en_q);
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            nmi_pend_q <= 1'b0;
        else if (nmi_pulse)
            nmi_pend_q <= 1'b1;
        else if (st_q == IAT_WAIT && boundary && pick == 4'h0 && !insn_ctrl_end())
            nmi_pend_q <= 1'b0;
    end

    function automatic logic insn_ctrl_end();
        return insn_done && (insn_class == IAT_CL_CTRL);
    endfunction : insn_ctrl_end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q       <= IAT_IDLE;
            cnt_q      <= 5'h00;
            prio_ext_q <= 1'b0;
            vector_id  <= 4'h0;
            ret_next   <= 1'b0;
        end
        else
        begin
            unique case (st_q)
                IAT_IDLE:
                    if (|elig)
                    begin
                        st_q       <= IAT_PRIO;
                        prio_ext_q <= (pick < 4'h7);
                        cnt_q      <= (pick < 4'h7) ? `IAT_PRIO_EXT : `IAT_PRIO_INT;
                    end
                IAT_PRIO:
                    if (cnt_q == 5'h01)
                        st_q <= IAT_WAIT;
                    else
                        cnt_q <= 5'(cnt_q - 5'h01);
                IAT_WAIT:
                    if (boundary && !insn_ctrl_end())
                    begin
                        if (|elig)
                        begin
                            st_q      <= IAT_STACK;
                            cnt_q     <= acc_len(mem, st3, ws);
                            vector_id <= pick;
                            ret_next  <= ~insn_done;
                        end
                        else
                            st_q <= IAT_IDLE;
                    end
                IAT_STACK:
                    if (cnt_q == 5'h01)
                    begin
                        st_q  <= IAT_VECT;
                        cnt_q <= acc_len(mem, st3, ws);
                    end
                    else
                        cnt_q <= 5'(cnt_q - 5'h01);
                IAT_VECT:
                    if (cnt_q == 5'h01)
                    begin
                        st_q  <= IAT_PREF;
                        cnt_q <= acc_len(mem, st3, ws);
                    end
                    else
                        cnt_q <= 5'(cnt_q - 5'h01);
                IAT_PREF:
                    if (cnt_q == 5'h01)
                    begin
                        st_q  <= IAT_INTL;
                        cnt_q <= `IAT_INTERNAL;
                    end
                    else
                        cnt_q <= 5'(cnt_q - 5'h01);
                IAT_INTL:
                    if (cnt_q == 5'h01)
                        st_q <= IAT_IDLE;
                    else
                        cnt_q <= 5'(cnt_q - 5'h01);
                default:
                    st_q <= IAT_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            exc_phase <= IAT_IDLE;
            svc_start <= 1'b0;
        end
        else
        begin
            exc_phase <= st_q;
            svc_start <= (st_q == IAT_INTL) && (cnt_q == 5'h01);
        end
    end

    // instruction-end wait watchdog: flags a core that overruns the longest instruction
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wcnt_q      <= 6'h00;
            wait_over_q <= 1'b0;
        end
        else if (st_q == IAT_PRIO)
        begin
            wcnt_q      <= 6'h00;
            wait_over_q <= 1'b0;
        end
        else if (st_q == IAT_WAIT && !boundary)
        begin
            if (wcnt_q != 6'h3F)
                wcnt_q <= 6'(wcnt_q + 6'h01);
            if (wcnt_q >= cur_max(mem, st3, ws))
                wait_over_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            ccr_imask <= `IAT_IMASK_RST;
        else if (st_q == IAT_WAIT && boundary && !insn_ctrl_end() && (|elig))
            ccr_imask <= 1'b1;
        else if (ccr_wr)
            ccr_imask <= ccr_i_val;
    end

    // reset is the only other way out of break mode
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            break_mode <= 1'b0;
            wdt_halt   <= 1'b0;
        end
        else if (brk_now)
        begin
            break_mode <= 1'b1;
            wdt_halt   <= 1'b1;
        end
        else if (rtb_now)
        begin
            break_mode <= 1'b0;
            wdt_halt   <= 1'b0;
        end
    end

    // axi4-lite write channel: address and data taken in either order
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wbyte_q   <= 6'h00;
            wlane_q   <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `IAT_RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_have_q <= 1'b1;
                awaddr_q  <= awaddr;
                awready   <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_have_q <= 1'b1;
                wbyte_q  <= wdata[5:0];
                wlane_q  <= wstrb[0];
                wready   <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= (awaddr_q == `IAT_ADDR_CTRL || awaddr_q == `IAT_ADDR_FLAGS ||
                              awaddr_q == `IAT_ADDR_ENABLE || awaddr_q == `IAT_ADDR_STATUS)
                             ? `IAT_RESP_OKAY : `IAT_RESP_SLVERR;
            end
            else if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q <= `IAT_CTRL_RST;
            en_q   <= `IAT_EN_RST;
        end
        else if (wr_fire && wlane_q)
        begin
            if (awaddr_q == `IAT_ADDR_CTRL)
                ctrl_q <= wbyte_q;
            if (awaddr_q == `IAT_ADDR_ENABLE)
                en_q <= wbyte_q;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `IAT_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= `IAT_RESP_OKAY;
            unique case (araddr)
                `IAT_ADDR_CTRL:   rdata <= {26'h000_0000, ctrl_q};
                `IAT_ADDR_FLAGS:  rdata <= {26'h000_0000, ext_request_flag};
                `IAT_ADDR_ENABLE: rdata <= {26'h000_0000, en_q};
                `IAT_ADDR_STATUS: rdata <= {21'h00_0000, vector_id, wait_over_q, nmi_pend_q,
                                            ccr_imask, break_mode, st_q};
                default:
                begin
                    rdata <= 32'h0000_0000;
                    rresp <= `IAT_RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_prio_int_len: assert property ($rose(st_q == IAT_PRIO) && !prio_ext_q |=> st_q == IAT_WAIT)
        else $error("internal priority decision not one state");
    a_prio_ext_len: assert property ($rose(st_q == IAT_PRIO) && prio_ext_q
                                     |=> st_q == IAT_PRIO ##1 st_q == IAT_WAIT)
        else $error("external priority decision not two states");
    a_stack_onchip: assert property ($rose(st_q == IAT_STACK) && mem == IAT_MEM_ONCHIP
                                     |-> (st_q == IAT_STACK)[*4] ##1 st_q == IAT_VECT)
        else $error("on-chip stack save not four states");
    a_intl_len: assert property ($rose(st_q == IAT_INTL)
                                 |-> (st_q == IAT_INTL)[*4] ##1 st_q == IAT_IDLE)
        else $error("internal processing not four states");
    a_phase_order: assert property (st_q == IAT_VECT |=> st_q inside {IAT_VECT, IAT_PREF})
        else $error("vector fetch left out of order");
    a_ctrl_inhibit: assert property (st_q == IAT_WAIT && insn_done && insn_class == IAT_CL_CTRL
                                     |=> st_q == IAT_WAIT)
        else $error("accepted after control instruction");
    a_break_block: assert property (break_mode && st_q == IAT_WAIT |=> st_q != IAT_STACK)
        else $error("interrupt accepted in break mode");
    a_mask_entry: assert property ($rose(st_q == IAT_STACK) |-> ccr_imask)
        else $error("mask not set on exception entry");
    a_svc_pulse: assert property ($fell(st_q == IAT_INTL) |-> svc_start)
        else $error("service start pulse missing");

endmodule : iat_core
`default_nettype wire

// ===== iat_cpu_model.sv
// cpu core model: ends one instruction every fourth cycle, block moves only on a class change
// assumes the bench picks the opcode and class of each instruction
`timescale 1ns/1ps
`default_nettype none
module iat_cpu_model (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic [15:0]         op_sel,
    input  wire iat_pkg::iat_class_t cls_sel,
    output logic                     insn_done,
    output logic [15:0]              insn_opcode,
    output iat_pkg::iat_class_t      insn_class,
    output logic                     xfer_boundary
);
    import iat_pkg::*;
    logic [1:0] cnt_q;
    logic       blk;
    always_ff @(posedge ref_clk or negedge resetn)
        if (!resetn) cnt_q <= 2'h0; else cnt_q <= cnt_q + 2'h1;
    // a block move keeps transferring for as long as the bench holds its class
    assign blk           = (cls_sel == IAT_CL_BLKB) || (cls_sel == IAT_CL_BLKW);
    assign insn_done     = &cnt_q && !blk;
    assign xfer_boundary = &cnt_q && (cls_sel == IAT_CL_BLKW);
    // zero opcode between ends keeps a stale break opcode off the boundary
    assign insn_opcode = insn_done ? op_sel : 16'h0000;
    assign insn_class  = cls_sel;
endmodule : iat_cpu_model
`default_nettype wire

// ===== interrupt_acceptance_timing_tb_top.sv
// bench: nmi response per memory setting, hold classes, break mode, reset
// assumes iat_cpu_model stands on the core side
`timescale 1ns/1ps
`default_nettype none
`include "iat_params.svh"
module interrupt_acceptance_timing_tb_top;
    import iat_pkg::*;
    logic ref_clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, nmi_pin = 0, ccr_wr = 0, seen, fin, ta, tw, awready, wready, bvalid;
    logic arready, rvalid, svc_start, ccr_imask, break_mode, wdt_halt, insn_done;
    logic ret_next, xfer_boundary;
    logic [5:0] irq_pin = 0;
    logic [7:0] awaddr = 0;
    logic [31:0] wdata = 0, rdata, got;
    logic [1:0] bresp, rresp, rsp, int_req = 0;
    logic [3:0] vector_id;
    logic [15:0] insn_opcode, op_sel = 0;
    iat_class_t insn_class, cls_sel = IAT_CL_NORMAL;
    iat_phase_t exc_phase, prev = IAT_IDLE;
    int len[8], run, cyc, num_errors, total_checks;
    logic [5:0] rows_c[5] = '{6'h01, 6'h03, 6'h0B, 6'h1D, 6'h2B};
    int rows_l[5] = '{4, 8, 12, 8, 20};
    always #2 ref_clk = ~ref_clk;
    iat_core i_iat_core (.ref_clk, .resetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
        .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr(awaddr),
        .rvalid, .rready, .rdata, .rresp, .nmi_pin, .irq_pin, .int_req, .insn_done,
        .insn_opcode, .insn_class, .xfer_boundary, .ccr_wr, .ccr_i_val(1'b0),
        .exc_phase, .svc_start, .vector_id, .ret_next, .ccr_imask, .break_mode, .wdt_halt);
    iat_cpu_model i_iat_cpu_model (.ref_clk, .resetn, .op_sel, .cls_sel, .insn_done,
        .insn_opcode, .insn_class, .xfer_boundary);
    // run lengths sampled mid-cycle, clear of the edge that moves the phase
    always @(negedge ref_clk)
    begin
        if (exc_phase != prev) begin len[prev] = run; run = 0; end
        run++;
        prev = exc_phase;
    end
    always @(posedge ref_clk)
        if (++cyc == 20000) begin num_errors++; end_sim; end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] g, input int e);
        total_checks++;
        if (g !== 32'(e)) num_errors++;
        if (g !== 32'(e)) $display("BAD %0t got %0h want %0h", $time, g, e);
    endtask : chk
    // each valid drops at the edge that takes it
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        awvalid <= w; wvalid <= w; bready <= w; arvalid <= !w; rready <= !w;
        awaddr <= a; wdata <= d;
        repeat (40)
        begin
            @(negedge ref_clk);
            ta = (awvalid && awready) || (arvalid && arready);
            tw = wvalid && wready;
            fin = w ? bvalid : rvalid; rsp = w ? bresp : rresp; got = rdata;
            @(posedge ref_clk);
            if (ta) begin awvalid <= 0; arvalid <= 0; end
            if (tw) wvalid <= 0;
            if (fin) break;
        end
        bready <= 0; rready <= 0;
        @(posedge ref_clk);
        chk(fin, 1);
    endtask : bus
    task automatic ws(input int lim);
        seen = 0;
        repeat (lim) if (!seen) begin @(negedge ref_clk); seen = svc_start; end
        @(posedge ref_clk);
    endtask : ws
    initial
    begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1;
        @(posedge ref_clk);
        foreach (rows_c[i])
        begin
            bus(1, `IAT_ADDR_CTRL, rows_c[i]);
            nmi_pin <= 1; ws(300);
            repeat (4) @(posedge ref_clk);
            chk(seen, 1);
            chk(len[IAT_PRIO], 2);
            chk(len[IAT_STACK], rows_l[i]);
            chk(len[IAT_VECT], rows_l[i]);
            chk(len[IAT_PREF], rows_l[i]);
            chk(len[IAT_INTL], 4);
            chk(vector_id, 0);
            nmi_pin <= 0; ws(40);
            chk(seen, 0);
            $display("timing row %0d done", i);
        end
        for (int k = 0; k < 2; k++)
        begin
            cls_sel <= k ? IAT_CL_BLKB : IAT_CL_CTRL; nmi_pin <= 1; ws(80);
            chk(seen, 0);
            cls_sel <= IAT_CL_NORMAL; ws(300);
            chk(seen, 1);
            if (k == 0) bus(0, `IAT_ADDR_STATUS, 0);
            if (k == 0) chk(got[6], 1);
            nmi_pin <= 0; repeat (4) @(posedge ref_clk);
        end
        cls_sel <= IAT_CL_BLKW; nmi_pin <= 1; ws(300);
        chk(seen, 1);
        chk(ret_next, 1);
        cls_sel <= IAT_CL_NORMAL; nmi_pin <= 0; repeat (4) @(posedge ref_clk);
        $display("hold classes done");
        op_sel <= `IAT_BRK_OP; repeat (8) @(posedge ref_clk);
        nmi_pin <= 1; ws(60);
        chk(seen, 0);
        chk(wdt_halt, 1);
        op_sel <= `IAT_RTB_OP; ws(300);
        chk(seen, 1);
        chk(break_mode, 0);
        op_sel <= `IAT_BRK_OP; repeat (8) @(posedge ref_clk);
        chk(break_mode, 1);
        resetn <= 0; op_sel <= 16'h0000; repeat (8) @(posedge ref_clk);
        resetn <= 1; @(posedge ref_clk);
        chk(break_mode, 0);
        chk(ccr_imask, 1);
        bus(0, 8'h10, 0);
        chk(rsp, `IAT_RESP_SLVERR);
        $display("break and reset done");
        ccr_wr <= 1; @(posedge ref_clk);
        ccr_wr <= 0; int_req <= 2'h3; ws(300);
        chk(seen, 1);
        chk(len[IAT_PRIO], 1);
        chk(vector_id, 7);
        chk(ret_next, 0);
        chk(ccr_imask, 1);
        int_req <= 2'h0;
        irq_pin <= 6'h03; repeat (8) @(posedge ref_clk);
        bus(0, `IAT_ADDR_FLAGS, 0);
        chk(got, 32'h0000_0003);
        irq_pin <= 6'h07; repeat (8) @(posedge ref_clk);
        bus(1, `IAT_ADDR_FLAGS, 32'h0000_003E);
        bus(0, `IAT_ADDR_FLAGS, 0);
        chk(got, 32'h0000_0006);
        irq_pin <= 6'h0F; repeat (8) @(posedge ref_clk);
        bus(1, `IAT_ADDR_FLAGS, 0);
        bus(0, `IAT_ADDR_FLAGS, 0);
        chk(got, 32'h0000_0000);
        $display("internal request and flag tests done");
        end_sim;
    end
endmodule : interrupt_acceptance_timing_tb_top
`default_nettype wire
